// [hdl/rdiers_pkg.sv]
// Purpose: Shared constants for the reader status and error register bank.
// Assumes: Registers sit at six-bit addresses on the device register port.
// Notes:   Every offset, bit position, reset value and count is named here once.
package rdiers_pkg;

   // ----------------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------------
   localparam logic [5:0] RDIERS_ADDR_AUX_IRQ = 6'h05;
   localparam logic [5:0] RDIERS_ADDR_ERROR   = 6'h06;
   localparam logic [5:0] RDIERS_ADDR_STATUS  = 6'h07;

   // ----------------------------------------------------------------------
   // Secondary request register fields
   // ----------------------------------------------------------------------
   localparam int RDIERS_B_MARKER   = 7;
   localparam int RDIERS_B_EDGE_REQ = 4;
   localparam int RDIERS_B_CRC_REQ  = 2;

   // ----------------------------------------------------------------------
   // Error register fields
   // ----------------------------------------------------------------------
   localparam int RDIERS_B_WRITE_ERR = 7;
   localparam int RDIERS_B_HEAT_ERR  = 6;
   localparam int RDIERS_B_OVFL_ERR  = 4;
   localparam int RDIERS_B_COLL_ERR  = 3;
   localparam int RDIERS_B_CRC_ERR   = 2;
   localparam int RDIERS_B_PAR_ERR   = 1;
   localparam int RDIERS_B_FRAME_ERR = 0;

   // Bits that command start leaves alone, and bits receiver start-up clears.
   localparam logic [7:0] RDIERS_KEEP_ON_CMD   = 8'h40;
   localparam logic [7:0] RDIERS_CLR_ON_RXSTRT = 8'h0F;
   localparam logic [7:0] RDIERS_ERR_USED      = 8'hDF;

   // ----------------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------------
   localparam int RDIERS_B_CRC_OK    = 6;
   localparam int RDIERS_B_CRC_READY = 5;
   localparam int RDIERS_B_IRQ       = 4;
   localparam int RDIERS_B_TIMER     = 3;
   localparam int RDIERS_B_HI_ALERT  = 1;
   localparam int RDIERS_B_LO_ALERT  = 0;

   // ----------------------------------------------------------------------
   // Reset values and FIFO size
   // ----------------------------------------------------------------------
   localparam logic [7:0] RDIERS_RST_AUX_IRQ = 8'h00;
   localparam logic [7:0] RDIERS_RST_ERROR   = 8'h00;
   localparam logic [7:0] RDIERS_RST_STATUS  = 8'h21;
   localparam logic [6:0] RDIERS_FIFO_DEPTH  = 7'h40;

endpackage

// [hdl/rdiers_edge_if.sv]
// Purpose: Carries the contactless input level to the edge detector and the edge event back.
// Assumes: Both ends run on the one system clock.
// Notes:   The edge signal is a one-cycle pulse.
`timescale 1ns/100ps

interface rdiers_edge_if;
   logic level;
   logic edge_seen;

   // The detector reads the level and reports edges.
   modport sense (input level, output edge_seen);
   // The register bank drives the level and consumes edges.
   modport user  (output level, input edge_seen);
endinterface

// [hdl/rdiers_edge.sv]
// Purpose: Detects rising and falling edges on the contactless serial input.
// Assumes: The input level is already synchronous to mclk.
// Notes:   The first sample after reset only primes the detector, so no false edge is reported.
`timescale 1ns/100ps

module rdiers_edge (
   input  wire logic  mclk,
   input  wire logic  rst_b,
   rdiers_edge_if.sense port_if
);

   typedef struct packed {
      logic prev;
      logic primed;
      logic pulse;
   } rdiers_edge_state_t;

   rdiers_edge_state_t state_ff;
   rdiers_edge_state_t nxt_state;

   // Either edge direction raises the pulse for one cycle.
   always_comb begin
      nxt_state        = state_ff;
      nxt_state.prev   = port_if.level;
      nxt_state.primed = 1'b1;
      nxt_state.pulse  = state_ff.primed && (port_if.level != state_ff.prev);
   end

   // State register.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign port_if.edge_seen = state_ff.pulse;

   default clocking edge_cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   chk_edge_pulse_once: assert property (state_ff.pulse |=> !state_ff.pulse || (port_if.level != $past(port_if.level)))
      else $error("edge pulse held without a new edge");

endmodule

// [hdl/rdiers_top.sv]
// Purpose: Secondary request, error and status registers of a contactless reader.
// Assumes: Register port and event inputs are synchronous to mclk; read data follows one cycle later.
// Notes:   Status bits other than the registered checksum flags are computed live; all are sampled into read data at the read strobe.
`timescale 1ns/100ps

module rdiers_top
   import rdiers_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic [5:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       cmd_start,
   input  wire logic       checksum_compute_cmd,
   input  wire logic       authentication_cmd,
   input  wire logic       crc_busy,
   input  wire logic       crc_data_done,
   input  wire logic       crc_result_zero,
   input  wire logic       host_fifo_write,
   input  wire logic       internal_fifo_write,
   input  wire logic       fifo_full,
   input  wire logic       fifo_flush,
   input  wire logic       rf_tx_rx_window,
   input  wire logic       overheat,
   input  wire logic       overheat_clear,
   input  wire logic       rate_106,
   input  wire logic       rx_startup,
   input  wire logic       collision_detect,
   input  wire logic       receive_checksum_enable,
   input  wire logic       crc_check_fail,
   input  wire logic       parity_fail,
   input  wire logic       sof_bad,
   input  wire logic       auth_byte_count_bad,
   input  wire logic       timer_counting,
   input  wire logic       timer_gate_enabled,
   input  wire logic [1:0] timer_gate_select,
   input  wire logic [6:0] fifo_byte_count,
   input  wire logic [5:0] fifo_threshold,
   input  wire logic [6:0] primary_irq_flags,
   input  wire logic [6:0] primary_enable_register,
   input  wire logic       contactless_edge_enable,
   input  wire logic       checksum_done_enable,
   input  wire logic       contactless_serial_input,
   output logic            antenna_off,
   output logic            irq_status,
   output logic            aux_irq
);

   // ----------------------------------------------------------------------
   // State and types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] aux;
      logic [7:0] err;
      logic       crc_ok;
      logic       crc_ready;
      logic [7:0] rdata;
      logic       antenna_off;
      logic       irq;
      logic       aux_irq;
   } rdiers_state_t;

   rdiers_state_t state_ff;
   rdiers_state_t nxt_state;

   logic [7:0] err_set;
   logic [7:0] status_live;
   logic       crc_done_evt;
   logic       aux_write;
   logic       hi_alert;
   logic       lo_alert;
   logic       timer_active;
   logic       any_request;
   logic       aux_pending;

   rdiers_edge_if edge_if ();

   // ----------------------------------------------------------------------
   // Edge detector on the contactless input
   // ----------------------------------------------------------------------
   assign edge_if.level = contactless_serial_input;

   rdiers_edge u_edge (
      .mclk    (mclk),
      .rst_b   (rst_b),
      .port_if (edge_if)
   );

   // ----------------------------------------------------------------------
   // Event decode and live status
   // ----------------------------------------------------------------------

   // Decoded events; kept as wires so that the checks below can see the cause.
   always_comb begin
      aux_write    = reg_wr && (reg_addr == RDIERS_ADDR_AUX_IRQ);
      crc_done_evt = checksum_compute_cmd && crc_data_done;
      err_set      = '0;
      err_set[RDIERS_B_WRITE_ERR] = host_fifo_write && (authentication_cmd || rf_tx_rx_window);
      err_set[RDIERS_B_HEAT_ERR]  = overheat;
      err_set[RDIERS_B_OVFL_ERR]  = (host_fifo_write || internal_fifo_write) && fifo_full;
      err_set[RDIERS_B_COLL_ERR]  = collision_detect && rate_106;
      err_set[RDIERS_B_CRC_ERR]   = receive_checksum_enable && crc_check_fail;
      err_set[RDIERS_B_PAR_ERR]   = parity_fail;
      err_set[RDIERS_B_FRAME_ERR] = (sof_bad && rate_106) || (authentication_cmd && auth_byte_count_bad);
   end

   // Alerts, timer and interrupt summary are combinational so a read never sees stale values.
   always_comb begin
      hi_alert     = (RDIERS_FIFO_DEPTH - fifo_byte_count) <= {1'b0, fifo_threshold};
      lo_alert     = fifo_byte_count <= {1'b0, fifo_threshold};
      // In gated mode the gate level itself is ignored; only the enable counts.
      timer_active = (timer_gate_select != 2'h0) ? timer_gate_enabled : timer_counting;
      aux_pending  = (state_ff.aux[RDIERS_B_EDGE_REQ] && contactless_edge_enable) ||
                     (state_ff.aux[RDIERS_B_CRC_REQ] && checksum_done_enable);
      any_request  = (|(primary_irq_flags & primary_enable_register)) || aux_pending;
      status_live  = '0;
      status_live[RDIERS_B_CRC_OK]    = state_ff.crc_ok;
      status_live[RDIERS_B_CRC_READY] = state_ff.crc_ready;
      status_live[RDIERS_B_IRQ]       = any_request;
      status_live[RDIERS_B_TIMER]     = timer_active;
      status_live[RDIERS_B_HI_ALERT]  = hi_alert;
      status_live[RDIERS_B_LO_ALERT]  = lo_alert;
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------

   // Clears are applied first and hardware sets afterwards, so an event in the
   // cycle of its clear is never lost.
   always_comb begin
      nxt_state = state_ff;

      // Secondary requests: the marker picks set or clear for every marked bit.
      if (aux_write) begin
         if (reg_wdata[RDIERS_B_EDGE_REQ]) begin
            nxt_state.aux[RDIERS_B_EDGE_REQ] = reg_wdata[RDIERS_B_MARKER];
         end
         if (reg_wdata[RDIERS_B_CRC_REQ]) begin
            nxt_state.aux[RDIERS_B_CRC_REQ] = reg_wdata[RDIERS_B_MARKER];
         end
      end
      // Hardware only ever sets these flags.
      if (edge_if.edge_seen) begin
         nxt_state.aux[RDIERS_B_EDGE_REQ] = 1'b1;
      end
      if (crc_done_evt) begin
         nxt_state.aux[RDIERS_B_CRC_REQ] = 1'b1;
      end

      // Error clears: command start, receiver start-up, flush, and rate gating.
      if (cmd_start) begin
         nxt_state.err = nxt_state.err & RDIERS_KEEP_ON_CMD;
      end
      if (rx_startup) begin
         nxt_state.err = nxt_state.err & ~RDIERS_CLR_ON_RXSTRT;
      end
      if (fifo_flush) begin
         nxt_state.err[RDIERS_B_OVFL_ERR] = 1'b0;
      end
      if (!rate_106) begin
         nxt_state.err[RDIERS_B_COLL_ERR] = 1'b0;
      end
      // The overheat flag may only drop once the sensor itself has cooled.
      if (overheat_clear && !overheat) begin
         nxt_state.err[RDIERS_B_HEAT_ERR] = 1'b0;
      end
      // Error sets; the register port has no path to write them.
      nxt_state.err = (nxt_state.err | err_set) & RDIERS_ERR_USED;
      nxt_state.antenna_off = nxt_state.err[RDIERS_B_HEAT_ERR];

      // Checksum coprocessor status.
      if (cmd_start) begin
         nxt_state.crc_ready = 1'b0;
      end
      if (crc_busy) begin
         nxt_state.crc_ok = 1'b0;
      end
      if (crc_done_evt) begin
         nxt_state.crc_ok    = crc_result_zero;
         nxt_state.crc_ready = 1'b1;
      end

      // Read data is captured at the strobe; unmapped addresses read zero.
      if (reg_rd) begin
         unique case (reg_addr)
            RDIERS_ADDR_AUX_IRQ: nxt_state.rdata = state_ff.aux;
            RDIERS_ADDR_ERROR:   nxt_state.rdata = state_ff.err;
            RDIERS_ADDR_STATUS:  nxt_state.rdata = status_live;
            default:             nxt_state.rdata = 8'h00;
         endcase
      end

      // Outputs are registered copies of the live summary.
      nxt_state.irq     = any_request;
      nxt_state.aux_irq = aux_pending;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------

   // Reset clears the whole request register, both request bits and the unused bits alike.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff           <= '0;
         state_ff.aux       <= RDIERS_RST_AUX_IRQ;
         state_ff.err       <= RDIERS_RST_ERROR;
         state_ff.crc_ok    <= RDIERS_RST_STATUS[RDIERS_B_CRC_OK];
         state_ff.crc_ready <= RDIERS_RST_STATUS[RDIERS_B_CRC_READY];
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign reg_rdata   = state_ff.rdata;
   assign antenna_off = state_ff.antenna_off;
   assign irq_status  = state_ff.irq;
   assign aux_irq     = state_ff.aux_irq;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking top_cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   chk_marker_set: assert property (aux_write && reg_wdata[RDIERS_B_MARKER] && reg_wdata[RDIERS_B_EDGE_REQ]
      |=> state_ff.aux[RDIERS_B_EDGE_REQ]) else $error("marked edge request not set");

   chk_marker_clear: assert property (aux_write && !reg_wdata[RDIERS_B_MARKER] && reg_wdata[RDIERS_B_CRC_REQ]
      && !crc_done_evt |=> !state_ff.aux[RDIERS_B_CRC_REQ]) else $error("marked request not cleared");

   chk_request_hold: assert property (state_ff.aux[RDIERS_B_EDGE_REQ] && !(aux_write && reg_wdata[RDIERS_B_EDGE_REQ])
      |=> state_ff.aux[RDIERS_B_EDGE_REQ]) else $error("request dropped by hardware");

   chk_input_edge: assert property ($changed(contactless_serial_input) ##1 1'b1
      |=> state_ff.aux[RDIERS_B_EDGE_REQ]) else $error("input edge missed");

   chk_checksum_done: assert property (crc_done_evt |=> state_ff.aux[RDIERS_B_CRC_REQ]
      && state_ff.crc_ready && (state_ff.crc_ok == $past(crc_result_zero))) else $error("checksum done lost");

   chk_heat_off: assert property (overheat |=> state_ff.err[RDIERS_B_HEAT_ERR] && antenna_off)
      else $error("overheat did not cut the antenna");

   chk_overflow_set: assert property (fifo_full && host_fifo_write
      |=> state_ff.err[RDIERS_B_OVFL_ERR]) else $error("overflow not flagged");

   chk_coll_rate: assert property (!rate_106 |=> !state_ff.err[RDIERS_B_COLL_ERR])
      else $error("collision flag at high rate");

   chk_cmd_clear: assert property (cmd_start |=> (state_ff.err & ~RDIERS_KEEP_ON_CMD)
      == ($past(err_set) & ~RDIERS_KEEP_ON_CMD)) else $error("command start left errors");

   chk_status_read: assert property (reg_rd && reg_addr == RDIERS_ADDR_STATUS |=>
      reg_rdata[RDIERS_B_HI_ALERT] == ((RDIERS_FIFO_DEPTH - $past(fifo_byte_count)) <= {1'b0, $past(fifo_threshold)})
      && reg_rdata[RDIERS_B_LO_ALERT] == ($past(fifo_byte_count) <= {1'b0, $past(fifo_threshold)}))
      else $error("alert read back wrong");

   chk_irq_summary: assert property (|(primary_irq_flags & primary_enable_register) |=> irq_status)
      else $error("enabled request not summarised");

   chk_aux_gate: assert property (!contactless_edge_enable && !checksum_done_enable |=> !aux_irq)
      else $error("secondary request passed while disabled");

   cov_edge_request: cover property (edge_if.edge_seen ##1 state_ff.aux[RDIERS_B_EDGE_REQ]);
   cov_checksum_ok: cover property (crc_busy ##[1:20] crc_done_evt && crc_result_zero);
   cov_flush_ovfl: cover property (state_ff.err[RDIERS_B_OVFL_ERR] ##1 fifo_flush);
   cov_cmd_clear: cover property (state_ff.err[RDIERS_B_PAR_ERR] ##1 cmd_start);

endmodule

// [sim/rdiers_host.sv]
// Purpose: Host model that drives the register port of the status bank.
// Assumes: The port samples strobes on the rising edge of mclk.
// Notes:   Strobes last one cycle; read data is taken a full cycle after the strobe edge.
`timescale 1ns/100ps

module rdiers_host (
   input  wire logic       mclk,
   output logic      [5:0] reg_addr,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // Idle values at time zero.
   initial begin
      {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
   end

   // One byte write; bit 7 carries the set or clear marker for request writes.
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge mclk);
      reg_wr    <= 1'h0;
      reg_wdata <= ~d;  // Stale data is inverted so nothing leans on it.
   endtask

   // One byte read; waiting one extra edge tolerates either reading of the answer cycle.
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge mclk);
      reg_rd   <= 1'h0;
      @(posedge mclk);
      #1 d = reg_rdata;
   endtask
endmodule

// [sim/rdiers_tb_top.sv]
// Purpose: Self-checking bench for the request, error and status registers.
// Assumes: Inputs change on the rising edge by non-blocking assignment.
// Notes:   Random status cases come from a fixed seed so every run is the same.
`timescale 1ns/100ps

module rdiers_tb_top;
   import rdiers_pkg::*;
   logic       mclk, rst_b, reg_wr, reg_rd, antenna_off, irq_status, aux_irq;
   logic [5:0] reg_addr, fifo_threshold;
   logic [7:0] reg_wdata, reg_rdata, rv, e;
   logic       cmd_start, checksum_compute_cmd, authentication_cmd, crc_busy, crc_data_done;
   logic       crc_result_zero, host_fifo_write, internal_fifo_write, fifo_full, fifo_flush;
   logic       rf_tx_rx_window, overheat, overheat_clear, rate_106, rx_startup, collision_detect;
   logic       receive_checksum_enable, crc_check_fail, parity_fail, sof_bad, auth_byte_count_bad;
   logic       timer_counting, timer_gate_enabled, contactless_edge_enable, checksum_done_enable;
   logic       contactless_serial_input;
   logic [1:0] timer_gate_select;
   logic [6:0] fifo_byte_count, primary_irq_flags, primary_enable_register;
   logic [7:0] err_exp [13] = '{8'h80, 8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h01,
                                8'h00, 8'h00, 8'h00, 8'h10};
   int         n_fail, comparisons, cyc, seed;

   rdiers_host host_u (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
   rdiers_top dut_u (.mclk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .cmd_start,
      .checksum_compute_cmd, .authentication_cmd, .crc_busy, .crc_data_done, .crc_result_zero,
      .host_fifo_write, .internal_fifo_write, .fifo_full, .fifo_flush, .rf_tx_rx_window, .overheat,
      .overheat_clear, .rate_106, .rx_startup, .collision_detect, .receive_checksum_enable,
      .crc_check_fail, .parity_fail, .sof_bad, .auth_byte_count_bad, .timer_counting,
      .timer_gate_enabled, .timer_gate_select, .fifo_byte_count, .fifo_threshold, .primary_irq_flags,
      .primary_enable_register, .contactless_edge_enable, .checksum_done_enable,
      .contactless_serial_input, .antenna_off, .irq_status, .aux_irq);

   // ----------------------------------------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------------------------------------
   // The clock runs at 20 MHz.
   initial begin
      mclk = 1'h0;
      forever #25 mclk = ~mclk;
   end

   // A hang is cut short well past the few hundred cycles the tests need.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_fail++;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] g);
      comparisons++;
      if (g !== ex) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, ex, g);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Codes below 13 raise error conditions for one cycle; 20 to 23 pulse a clearing event, any other code pulses checksum data done.
   task automatic ev(input int k);
      @(posedge mclk);
      case (k)
         0: {authentication_cmd, host_fifo_write} <= 2'h3;
         1: {rf_tx_rx_window, host_fifo_write} <= 2'h3;
         2: overheat <= 1'h1;
         3: {fifo_full, internal_fifo_write} <= 2'h3;
         4: {rate_106, collision_detect} <= 2'h3;
         5: {receive_checksum_enable, crc_check_fail} <= 2'h3;
         6: parity_fail <= 1'h1;
         7: {rate_106, sof_bad} <= 2'h3;
         8: {authentication_cmd, auth_byte_count_bad} <= 2'h3;
         9: {rate_106, collision_detect} <= 2'h1;  // Refused away from 106 kBd.
         10: crc_check_fail <= 1'h1;  // Refused with checking disabled.
         11: {rate_106, sof_bad} <= 2'h1;
         12: {fifo_full, host_fifo_write} <= 2'h3;
         20: cmd_start <= 1'h1;
         21: overheat_clear <= 1'h1;
         22: rx_startup <= 1'h1;
         23: fifo_flush <= 1'h1;
         default: crc_data_done <= 1'h1;
      endcase
      @(posedge mclk);
      // The link rate is a level and stays put, since any rate other than 106 kBd clears the collision flag at once.
      {authentication_cmd, host_fifo_write, rf_tx_rx_window, overheat, fifo_full, internal_fifo_write,
       collision_detect, receive_checksum_enable, crc_check_fail, parity_fail, sof_bad,
       auth_byte_count_bad, cmd_start, overheat_clear, rx_startup, fifo_flush, crc_data_done} <= '0;
   endtask

   // Live status bits 4, 3, 1 and 0 worked out from the inputs.
   function automatic logic [7:0] exp_st(input logic [6:0] n, input logic [5:0] w, input logic e2);
      exp_st = 8'h00;
      exp_st[RDIERS_B_IRQ] = (|(primary_irq_flags & primary_enable_register)) | e2;
      exp_st[RDIERS_B_TIMER] = (timer_gate_select != 2'h0) ? timer_gate_enabled : timer_counting;
      exp_st[RDIERS_B_HI_ALERT] = (RDIERS_FIFO_DEPTH - n) <= {1'h0, w};
      exp_st[RDIERS_B_LO_ALERT] = n <= {1'h0, w};
   endfunction

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      {n_fail, comparisons, cyc} = '0;
      seed = 97;
      rst_b = 1'h0;
      {cmd_start, checksum_compute_cmd, authentication_cmd, crc_busy, crc_data_done, crc_result_zero,
       host_fifo_write, internal_fifo_write, fifo_full, fifo_flush, rf_tx_rx_window, overheat,
       overheat_clear, rate_106, rx_startup, collision_detect, receive_checksum_enable, crc_check_fail,
       parity_fail, sof_bad, auth_byte_count_bad, timer_counting, timer_gate_enabled,
       contactless_edge_enable, checksum_done_enable, contactless_serial_input, timer_gate_select,
       fifo_byte_count, fifo_threshold, primary_irq_flags, primary_enable_register} = '0;
      repeat (10) @(posedge mclk);
      rst_b <= 1'h1;
      host_u.rd(RDIERS_ADDR_AUX_IRQ, rv);
      chk("aux reset", 8'h00, rv & 8'h0F);
      host_u.rd(RDIERS_ADDR_ERROR, rv);
      chk("err reset", RDIERS_RST_ERROR, rv);
      host_u.rd(RDIERS_ADDR_STATUS, rv);
      chk("status reset", RDIERS_RST_STATUS, rv);
      host_u.rd(6'h3F, rv);
      chk("unmapped", 8'h00, rv);
      $display("test reset done");
      // Set both requests, then clear them one at a time.
      host_u.wr(RDIERS_ADDR_AUX_IRQ, 8'h94);
      host_u.rd(RDIERS_ADDR_AUX_IRQ, rv);
      chk("aux set", 8'h14, rv);
      host_u.wr(RDIERS_ADDR_AUX_IRQ, 8'h6B);
      host_u.rd(RDIERS_ADDR_AUX_IRQ, rv);
      chk("aux kept", 8'h14, rv);
      host_u.wr(RDIERS_ADDR_AUX_IRQ, 8'h04);
      host_u.rd(RDIERS_ADDR_AUX_IRQ, rv);
      chk("aux clear", 8'h10, rv);
      host_u.wr(RDIERS_ADDR_AUX_IRQ, 8'h10);
      // Both edge directions set the request; the enable gates the output.
      for (int i = 0; i < 2; i++) begin
         contactless_edge_enable <= i[0];
         contactless_serial_input <= ~contactless_serial_input;
         repeat (4) @(posedge mclk);
         host_u.rd(RDIERS_ADDR_AUX_IRQ, rv);
         chk("edge req", 8'h10, rv);
         chk("edge irq", {7'h00, i[0]}, {7'h00, aux_irq});
         chk("irq status", {7'h00, i[0]}, {7'h00, irq_status});
         host_u.wr(RDIERS_ADDR_AUX_IRQ, 8'h10);
      end
      $display("test requests done");
      // Each error source alone, starting from a cleared register.
      for (int k = 0; k < 13; k++) begin
         ev(20);
         ev(21);
         ev(k);
         host_u.rd(RDIERS_ADDR_ERROR, rv);
         chk("err flag", err_exp[k], rv);
         chk("antenna", {7'h00, err_exp[k][6]}, {7'h00, antenna_off});
      end
      foreach (err_exp[k]) if (k < 7 && k != 1 && k != 4 && k != 5) ev(k);
      host_u.rd(RDIERS_ADDR_ERROR, rv);
      chk("err sum", 8'hD2, rv);
      ev(22);
      host_u.rd(RDIERS_ADDR_ERROR, rv);
      chk("rx start", 8'hD0, rv);
      ev(23);
      host_u.wr(RDIERS_ADDR_ERROR, 8'hFF);
      host_u.rd(RDIERS_ADDR_ERROR, rv);
      chk("flush", 8'hC0, rv);
      ev(20);
      host_u.rd(RDIERS_ADDR_ERROR, rv);
      chk("cmd start", 8'h40, rv);
      $display("test errors done");
      // Checksum command: residue low while busy, then finished and zero.
      checksum_compute_cmd <= 1'h1;
      crc_busy <= 1'h1;
      host_u.rd(RDIERS_ADDR_STATUS, rv);
      chk("crc busy", 8'h00, rv & 8'h40);
      crc_busy <= 1'h0;
      crc_result_zero <= 1'h1;
      ev(24);
      host_u.rd(RDIERS_ADDR_STATUS, rv);
      chk("crc done", 8'h60, rv & 8'h60);
      host_u.rd(RDIERS_ADDR_AUX_IRQ, rv);
      chk("crc req", 8'h04, rv);
      // A new calculation must pull the residue flag down from one.
      crc_busy <= 1'h1;
      host_u.rd(RDIERS_ADDR_STATUS, rv);
      chk("crc busy again", 8'h00, rv & 8'h40);
      crc_busy <= 1'h0;
      $display("test checksum done");
      // Random status mix; the first six cases step across the high alert boundary.
      for (int i = 0; i < 40; i++) begin
         e = (i < 6) ? 8'h04 : 8'h00;
         fifo_byte_count <= (i < 6) ? 7'(60 - i) : 7'($unsigned($random(seed)) % 65);
         fifo_threshold <= (i < 6) ? 6'h04 : 6'($random(seed));
         {timer_gate_select, timer_gate_enabled, timer_counting} <= 4'($random(seed));
         {primary_irq_flags, primary_enable_register} <= 14'($random(seed));
         checksum_done_enable <= 1'($random(seed));
         @(posedge mclk);
         host_u.rd(RDIERS_ADDR_STATUS, rv);
         e = exp_st(fifo_byte_count, fifo_threshold, checksum_done_enable);
         chk("status", e, rv & 8'h1B);
         chk("irq out", {7'h00, e[4]}, {7'h00, irq_status});
      end
      $display("test status done");
      stop_test();
   end
endmodule
